// ---- dv/slm_board_model.sv ----
// board side: strap resistors and external current monitors
`timescale 1ns/1ps
module slm_board_model (
    // strap and monitor settings
    input  wire logic [5:0] pos_set,
    input  wire logic [5:0] neg_set,
    input  wire logic [5:0] oc_set,
    // wires to and from the hub
    output logic      [5:0] pos_strap,
    output logic      [5:0] neg_strap,
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] pin_oe_n,
    output logic      [5:0] pin_lvl
);
    // a port is meant off only with both lines tied high
    assign pos_strap = pos_set;
    assign neg_strap = neg_set;
    // hub drive wins, else the monitor pulls low on overcurrent, else pull-up
    assign pin_lvl = (~pin_oe_n & pin_o) | (pin_oe_n & ~oc_set);
endmodule

// ---- dv/slm_strap_latch_props.sv ----
// concurrent checks on the strap latch ports
`timescale 1ns/1ps
module slm_strap_latch_props #(
    parameter int NUM_PORTS = slm_pkg::NUM_PORTS,
    parameter int NUM_PF    = slm_pkg::NUM_PF
) (
    // clock, reset, straps and controls
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic [NUM_PORTS-1:0]   port_pos_line_disable_strap,
    input wire logic [NUM_PORTS-1:0]   port_neg_line_disable_strap,
    input wire logic [2:0]             fixed_device_port_strap,
    input wire logic [2:0]             charging_ports_strap,
    input wire logic [2:0]             mode2_strap,
    input wire logic [2:0]             mode1_strap,
    input slm_pkg::slm_mux_wr_t        mux_wr,
    input wire logic [NUM_PORTS-1:0]   host_port_disable,
    input wire logic                   microphone_detect,
    // pins and decoded state
    input wire logic [NUM_PORTS-1:0]   port_power_overcurrent_pin_i,
    input wire logic [NUM_PORTS-1:0]   port_power_overcurrent_pin_o,
    input wire logic [NUM_PORTS-1:0]   port_power_overcurrent_pin_oe_n,
    input wire logic [NUM_PORTS-1:0]   port_power_overcurrent_pin_pu,
    input slm_pkg::slm_defaults_t      defaults,
    input slm_pkg::slm_straps_t        straps_captured,
    input wire logic                   mic_present,
    input wire logic [NUM_PORTS-1:0]   overcurrent,
    input wire logic [NUM_PF-1:0][5:0] pin_function
);
    logic [2:0] run_cnt;
    logic [4:0] wr_pin_r;
    logic [5:0] wr_fn_r;
    wire        settled = run_cnt == 3'h7;
    function automatic logic [5:0] lmask(input logic [2:0] l);
        return l > 3'h4 ? 6'h3F : (6'h01 << l) - 6'h01;
    endfunction
    // saturating age since reset, so every past value is from the same run
    always_ff @(posedge sys_clk) begin
        if (rst) run_cnt <= 3'h0;
        else if (!settled) run_cnt <= run_cnt + 3'h1;
    end
    always_ff @(posedge sys_clk) begin
        wr_pin_r <= mux_wr.pin;
        wr_fn_r  <= mux_wr.func;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_release;
        $past(rst) && !rst;
    endsequence
    sequence s_mux_wr;
        settled && mux_wr.valid && mux_wr.pin >= 5'h03;
    endsequence
    a_capture_release: assert property (s_release |=> straps_captured == {
        $past(port_pos_line_disable_strap, 3), $past(port_neg_line_disable_strap, 3),
        $past(fixed_device_port_strap, 3), $past(charging_ports_strap, 3),
        $past(mode2_strap, 3), $past(mode1_strap, 3)}) else $error("capture wrong");
    a_pin_default: assert property (s_release |=> pin_function[0] ==
        ((straps_captured.mode2_lvl == 3'h0 && straps_captured.mode1_lvl == 3'h2)
        ? 6'h01 : 6'h00)) else $error("pin default wrong");
    a_strap_hold: assert property (settled |-> $stable(straps_captured))
        else $error("captured straps moved");
    a_port_both: assert property (settled |-> defaults.port_disabled ==
        (straps_captured.pos_dis & straps_captured.neg_dis)) else $error("port off wrong");
    a_ss_follows: assert property (settled |-> defaults.ss_disabled ==
        defaults.port_disabled) else $error("superspeed half wrong");
    a_fixed_mask: assert property (settled && straps_captured.fixed_lvl <= 3'h5 |->
        defaults.fixed_ports == lmask(straps_captured.fixed_lvl)) else $error("fixed wrong");
    a_charge_mask: assert property (settled && straps_captured.charge_lvl <= 3'h5 |->
        defaults.dcp_enable == lmask(straps_captured.charge_lvl) &&
        defaults.cdp_enable == defaults.dcp_enable) else $error("charging wrong");
    a_mode_valid: assert property (settled |-> defaults.mode_valid ==
        (straps_captured.mode2_lvl == 3'h0 && straps_captured.mode1_lvl == 3'h2))
        else $error("mode valid wrong");
    a_mux_visible: assert property (s_mux_wr |=>
        pin_function[wr_pin_r - 5'h03] == wr_fn_r) else $error("mux write lost");
    a_mic_level: assert property (settled |-> mic_present == $past(microphone_detect, 2))
        else $error("mic wrong");
    a_pin_drive: assert property (port_power_overcurrent_pin_oe_n ==
        ~(defaults.port_disabled | host_port_disable) && port_power_overcurrent_pin_o == '0
        && port_power_overcurrent_pin_pu == port_power_overcurrent_pin_oe_n)
        else $error("port pin drive wrong");
    a_oc_cause: assert property (settled |->
        (overcurrent & $past(port_power_overcurrent_pin_i, 3)) == '0) else $error("false oc");
endmodule
bind slm_strap_latch slm_strap_latch_props #(.NUM_PORTS(NUM_PORTS), .NUM_PF(NUM_PF)) i_props (.*);

// ---- dv/strap_latch_and_pin_function_map_bench.sv ----
// self-checking bench for the strap latch and pin function map
`timescale 1ns/1ps
module strap_latch_and_pin_function_map_bench;
    logic                   sys_clk, rst, mic, mic_p;
    logic [5:0]             pos_set, neg_set, oc_set, pos_s, neg_s, host_dis;
    logic [5:0]             pin_lvl, pin_o, oe_n, pu, oc;
    logic [2:0]             fix_s, chg_s, m2_s, m1_s;
    slm_pkg::slm_mux_wr_t   mux_wr;
    slm_pkg::slm_defaults_t dflt;
    slm_pkg::slm_straps_t   cap;
    logic [28:0][5:0]       pin_fn;
    logic [5:0]             ex [29];
    logic [31:0]            seed;
    int                     err_count, n_tests;
    // default codes of pins 3..31, enum order
    localparam logic [5:0] DTAB [29] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h00, 6'h00,
        6'h06, 6'h07, 6'h08, 6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h09, 6'h0F, 6'h11, 6'h12, 6'h13,
        6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h0E, 6'h1A, 6'h1B, 6'h10};
    slm_strap_latch i_slm_strap_latch (
        .sys_clk(sys_clk), .rst(rst), .port_pos_line_disable_strap(pos_s),
        .port_neg_line_disable_strap(neg_s), .fixed_device_port_strap(fix_s),
        .charging_ports_strap(chg_s), .mode2_strap(m2_s), .mode1_strap(m1_s),
        .mux_wr(mux_wr), .host_port_disable(host_dis), .microphone_detect(mic),
        .port_power_overcurrent_pin_i(pin_lvl), .port_power_overcurrent_pin_o(pin_o),
        .port_power_overcurrent_pin_oe_n(oe_n), .port_power_overcurrent_pin_pu(pu),
        .defaults(dflt), .straps_captured(cap), .mic_present(mic_p),
        .overcurrent(oc), .pin_function(pin_fn));
    slm_board_model i_slm_board_model (
        .pos_set(pos_set), .neg_set(neg_set), .oc_set(oc_set), .pos_strap(pos_s),
        .neg_strap(neg_s), .pin_o(pin_o), .pin_oe_n(oe_n), .pin_lvl(pin_lvl));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [5:0] lmask(input logic [2:0] l);
        return l > 3'h4 ? 6'h3F : (6'h01 << l) - 6'h01;
    endfunction
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic mux(input logic [4:0] p);
        @(negedge sys_clk);
        mux_wr.valid = 1'b1;
        mux_wr.pin = p;
        mux_wr.func = slm_pkg::slm_func_t'(6'(xs() % 28));
        if (p > 5'h02) ex[p - 5'h03] = mux_wr.func;
    endtask
    task automatic run_case(input logic [5:0] p, n, input logic [2:0] f, c, a, b);
        logic v;
        @(negedge sys_clk);
        rst = 1'b1;
        {pos_set, neg_set, fix_s, chg_s, m2_s, m1_s} = {p, n, f, c, a, b};
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        v = a == 3'h0 && b == 3'h2;
        chk("captured", cap, {p, n, f, c, a, b});
        chk("port_off", dflt.port_disabled, p & n);
        chk("ss_off", dflt.ss_disabled, p & n);
        chk("fixed", dflt.fixed_ports, lmask(f));
        chk("charge", {dflt.dcp_enable, dflt.cdp_enable}, {2{lmask(c)}});
        chk("mode", dflt.mode_valid, v);
        for (int i = 0; i < 29; i++) ex[i] = v ? DTAB[i] : 6'h00;
        // late strap moves, host, monitor and mic traffic
        {pos_set, neg_set, fix_s} = ~{p, n, f};
        host_dis = 6'(xs());
        oc_set = 6'(xs());
        mic = 1'(xs() >> 7);
        mux(5'(3 + xs() % 29));
        mux(5'(3 + xs() % 29));
        mux(5'h02);
        mux(5'h1F);
        @(negedge sys_clk);
        mux_wr.valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < 29; i++) chk("pin_fn", pin_fn[i], ex[i]);
        chk("held", cap, {p, n, f, c, a, b});
        chk("pins", {oe_n, pu}, {2{6'(~(p & n | host_dis))}});
        chk("oc", oc, oc_set & 6'(~(p & n | host_dis)));
        chk("mic", mic_p, mic);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h8DCE;
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        {pos_set, neg_set, oc_set, host_dis, fix_s, chg_s, m2_s, m1_s, mic} = '0;
        mux_wr = '0;
        run_case(6'h3F, 6'h3F, 3'h5, 3'h5, 3'h0, 3'h2);
        run_case(6'h15, 6'h2A, 3'h0, 3'h0, 3'h0, 3'h2);
        // odd rounds draw mode levels, mostly reserved ones
        for (int k = 0; k < 14; k++)
            run_case(6'(xs()), 6'(xs()), 3'(k % 6), 3'(5 - k % 6),
                k[0] ? 3'(xs() % 6) : 3'h0, k[0] ? 3'(xs() % 6) : 3'h2);
        tally_and_finish();
    end
endmodule

// ---- hw/slm_level_mask.sv ----
// maps a six-level strap reading onto a lowest-ports-first mask
`timescale 1ns/1ps
module slm_level_mask (
    // level in
    input  wire logic [2:0] level,
    // port mask out
    output logic      [5:0] mask
);
    always_comb begin
        case (slm_pkg::slm_level_t'(level))
            slm_pkg::SLM_LVL_PD_WEAK:   mask = slm_pkg::MASK_NONE;
            slm_pkg::SLM_LVL_PU_WEAK:   mask = slm_pkg::MASK_P1;
            slm_pkg::SLM_LVL_PD_MED:    mask = slm_pkg::MASK_P12;
            slm_pkg::SLM_LVL_PU_MED:    mask = slm_pkg::MASK_P13;
            slm_pkg::SLM_LVL_PD_STRONG: mask = slm_pkg::MASK_P14;
            slm_pkg::SLM_LVL_PU_STRONG: mask = slm_pkg::MASK_ALL;
            // unreadable codes count as the safe weakest setting
            default:                    mask = slm_pkg::MASK_NONE;
        endcase
    end
endmodule

// ---- hw/slm_pf_default.sv ----
// default function of each programmable pin in the single valid mode
`timescale 1ns/1ps
module slm_pf_default (
    // pin index 3..31
    input  wire logic [4:0] pin,
    // default function
    output slm_pkg::slm_func_t func
);
    always_comb begin
        case (pin)
            5'h03:   func = slm_pkg::SLM_FN_AUD_SDI;
            5'h04:   func = slm_pkg::SLM_FN_AUD_SDO;
            5'h05:   func = slm_pkg::SLM_FN_AUD_SCK;
            5'h06:   func = slm_pkg::SLM_FN_AUD_WS;
            5'h07:   func = slm_pkg::SLM_FN_AUD_MCLK;
            5'h0A:   func = slm_pkg::SLM_FN_SS_CTL3;
            5'h0B:   func = slm_pkg::SLM_FN_SS_CTL4;
            5'h0C:   func = slm_pkg::SLM_FN_SS_CTL5;
            5'h0D:   func = slm_pkg::SLM_FN_CTL5;
            5'h0E:   func = slm_pkg::SLM_FN_CTL4;
            5'h0F:   func = slm_pkg::SLM_FN_CTL3;
            5'h10:   func = slm_pkg::SLM_FN_CTL2;
            5'h11:   func = slm_pkg::SLM_FN_CTL1;
            5'h12:   func = slm_pkg::SLM_FN_BRIDGE_I2C_CLK;
            5'h13:   func = slm_pkg::SLM_FN_MIC_DETECT;
            5'h14:   func = slm_pkg::SLM_FN_SPI_CS;
            5'h15:   func = slm_pkg::SLM_FN_SPI_CLK;
            5'h16:   func = slm_pkg::SLM_FN_SPI_D0;
            5'h17:   func = slm_pkg::SLM_FN_SPI_D1;
            5'h18:   func = slm_pkg::SLM_FN_SPI_D2;
            5'h19:   func = slm_pkg::SLM_FN_SPI_D3;
            5'h1A:   func = slm_pkg::SLM_FN_TARGET_I2C_CLK;
            5'h1B:   func = slm_pkg::SLM_FN_TARGET_I2C_DATA;
            5'h1C:   func = slm_pkg::SLM_FN_CTL6;
            5'h1D:   func = slm_pkg::SLM_FN_GENERAL_IO;
            5'h1E:   func = slm_pkg::SLM_FN_UP_VBUS_MON;
            5'h1F:   func = slm_pkg::SLM_FN_BRIDGE_I2C_DATA;
            // PF8, PF9 and anything outside 3..31 stay unconnected
            default: func = slm_pkg::SLM_FN_NC;
        endcase
    end
endmodule

// ---- hw/slm_pkg.sv ----
// package: strap encodings, pin function codes, reset values and carrier structs
package slm_pkg;

    localparam int NUM_PORTS = 6;
    localparam int NUM_PF    = 29;
    localparam int PF_FIRST  = 3;

    // six-level strap reading, weakest pull-down first
    typedef enum logic [2:0] {
        SLM_LVL_PD_WEAK,
        SLM_LVL_PU_WEAK,
        SLM_LVL_PD_MED,
        SLM_LVL_PU_MED,
        SLM_LVL_PD_STRONG,
        SLM_LVL_PU_STRONG
    } slm_level_t;

    // port masks per level, port 1 in bit 0
    localparam logic [5:0] MASK_NONE = 6'h00;
    localparam logic [5:0] MASK_P1   = 6'h01;
    localparam logic [5:0] MASK_P12  = 6'h03;
    localparam logic [5:0] MASK_P13  = 6'h07;
    localparam logic [5:0] MASK_P14  = 6'h0F;
    localparam logic [5:0] MASK_ALL  = 6'h3F;

    // reset values of the captured straps
    localparam logic [5:0] RST_DIS   = 6'h00;
    localparam logic [2:0] RST_LEVEL = 3'h0;

    // pin function codes
    typedef enum logic [5:0] {
        SLM_FN_NC,
        SLM_FN_AUD_SDI,
        SLM_FN_AUD_SDO,
        SLM_FN_AUD_SCK,
        SLM_FN_AUD_WS,
        SLM_FN_AUD_MCLK,
        SLM_FN_SS_CTL3,
        SLM_FN_SS_CTL4,
        SLM_FN_SS_CTL5,
        SLM_FN_CTL1,
        SLM_FN_CTL2,
        SLM_FN_CTL3,
        SLM_FN_CTL4,
        SLM_FN_CTL5,
        SLM_FN_CTL6,
        SLM_FN_BRIDGE_I2C_CLK,
        SLM_FN_BRIDGE_I2C_DATA,
        SLM_FN_MIC_DETECT,
        SLM_FN_SPI_CS,
        SLM_FN_SPI_CLK,
        SLM_FN_SPI_D0,
        SLM_FN_SPI_D1,
        SLM_FN_SPI_D2,
        SLM_FN_SPI_D3,
        SLM_FN_TARGET_I2C_CLK,
        SLM_FN_TARGET_I2C_DATA,
        SLM_FN_GENERAL_IO,
        SLM_FN_UP_VBUS_MON
    } slm_func_t;

    // captured strap image
    typedef struct packed {
        logic [5:0] pos_dis;
        logic [5:0] neg_dis;
        logic [2:0] fixed_lvl;
        logic [2:0] charge_lvl;
        logic [2:0] mode2_lvl;
        logic [2:0] mode1_lvl;
    } slm_straps_t;

    // decoded defaults
    typedef struct packed {
        logic [5:0] port_disabled;
        logic [5:0] ss_disabled;
        logic [5:0] fixed_ports;
        logic [5:0] dcp_enable;
        logic [5:0] cdp_enable;
        logic       mode_valid;
    } slm_defaults_t;

    // runtime pin-mux write
    typedef struct packed {
        logic       valid;
        logic [4:0] pin;
        slm_func_t  func;
    } slm_mux_wr_t;

endpackage

// ---- hw/slm_strap_latch.sv ----
// strap capture, default decode, pin function map and port control pins
//
// Function
// - sample all straps while reset is held, capture them when reset releases
// - positive-line strap: 0 keeps that data line enabled, 1 disables it
// - negative-line strap: 0 keeps that data line enabled, 1 disables it
// - port disabled only when both its line straps were high
// - disabling the USB 2.0 half also disables its SuperSpeed half
// - fixed-port and charging straps each resolve to one of six levels
// - fixed-port level sets none, 1, 1-2, 1-3, 1-4 or all ports
// - charging level enables both charging kinds on none up to all ports
// - only mode2 weak pull-down with mode1 medium pull-down is valid
// - pins 3-7 carry audio serial lines; pins 8, 9 unconnected
// - pins 10-12 SuperSpeed control 3-5, 13-17 control 5-1, 28 control 6
// - pins 18/31 bridge I2C, 19 mic, 20-25 SPI, 26-27 target I2C, 29, 30
// - pin-mux writes may replace any pin's strap default function
// - microphone detect high means plugged in, low means absent
// - port control pin is pulled-up input if enabled, driven low if disabled
// - enabled port control pin is watched for active-low overcurrent
`timescale 1ns/1ps
module slm_strap_latch #(
    parameter int NUM_PORTS = slm_pkg::NUM_PORTS,
    parameter int NUM_PF    = slm_pkg::NUM_PF
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // strap pins, sampled during reset
    input  wire logic [NUM_PORTS-1:0]       port_pos_line_disable_strap,
    input  wire logic [NUM_PORTS-1:0]       port_neg_line_disable_strap,
    input  wire logic [2:0]                 fixed_device_port_strap,
    input  wire logic [2:0]                 charging_ports_strap,
    input  wire logic [2:0]                 mode2_strap,
    input  wire logic [2:0]                 mode1_strap,
    // runtime pin-mux override and host port disable
    input  slm_pkg::slm_mux_wr_t            mux_wr,
    input  wire logic [NUM_PORTS-1:0]       host_port_disable,
    // microphone detect pin
    input  wire logic                       microphone_detect,
    // port power / overcurrent pins, index 0 is port 1
    input  wire logic [NUM_PORTS-1:0]       port_power_overcurrent_pin_i,
    output logic      [NUM_PORTS-1:0]       port_power_overcurrent_pin_o,
    output logic      [NUM_PORTS-1:0]       port_power_overcurrent_pin_oe_n,
    output logic      [NUM_PORTS-1:0]       port_power_overcurrent_pin_pu,
    // decoded state
    output slm_pkg::slm_defaults_t          defaults,
    output slm_pkg::slm_straps_t            straps_captured,
    output logic                            mic_present,
    output logic      [NUM_PORTS-1:0]       overcurrent,
    output logic      [NUM_PF-1:0][5:0]     pin_function
);
    slm_pkg::slm_straps_t   sample_s1_r;
    slm_pkg::slm_straps_t   sample_s2_r;
    slm_pkg::slm_straps_t   cap_r;
    slm_pkg::slm_defaults_t def_nxt;
    slm_pkg::slm_defaults_t def_r;
    logic                   rst_d_r;
    logic [1:0]             mic_sync_r;
    logic [NUM_PORTS-1:0]   oc_s1_r;
    logic [NUM_PORTS-1:0]   oc_s2_r;
    logic [NUM_PORTS-1:0]   oc_r;
    logic [NUM_PORTS-1:0]   port_off;
    logic [5:0]             fixed_mask;
    logic [5:0]             charge_mask;
    logic                   mode_ok_live;

    // strap pins are asynchronous: two stages before the capture register
    always_ff @(posedge sys_clk) begin
        sample_s1_r <= {port_pos_line_disable_strap, port_neg_line_disable_strap,
                        fixed_device_port_strap, charging_ports_strap,
                        mode2_strap, mode1_strap};
        sample_s2_r <= sample_s1_r;
    end

    always_ff @(posedge sys_clk) begin
        rst_d_r <= rst;
    end

    // capture on the first edge after release, then freeze until next reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cap_r <= '{pos_dis: slm_pkg::RST_DIS, neg_dis: slm_pkg::RST_DIS,
                       fixed_lvl: slm_pkg::RST_LEVEL, charge_lvl: slm_pkg::RST_LEVEL,
                       mode2_lvl: slm_pkg::RST_LEVEL, mode1_lvl: slm_pkg::RST_LEVEL};
        end else if (rst_d_r) begin
            cap_r <= sample_s2_r;
        end
        // otherwise held: nothing resamples while running
    end

    slm_level_mask u_fixed_mask (
        .level (cap_r.fixed_lvl),
        .mask  (fixed_mask)
    );

    slm_level_mask u_charge_mask (
        .level (cap_r.charge_lvl),
        .mask  (charge_mask)
    );

    always_comb begin
        def_nxt               = '0;
        // each line strap alone only marks its own line; port needs both
        def_nxt.port_disabled = cap_r.pos_dis & cap_r.neg_dis;
        def_nxt.ss_disabled   = cap_r.pos_dis & cap_r.neg_dis;
        def_nxt.fixed_ports   = fixed_mask;
        def_nxt.dcp_enable    = charge_mask;
        def_nxt.cdp_enable    = charge_mask;
        def_nxt.mode_valid    = (cap_r.mode2_lvl == 3'(slm_pkg::SLM_LVL_PD_WEAK))
                             && (cap_r.mode1_lvl == 3'(slm_pkg::SLM_LVL_PD_MED));
    end

    // pin table loads on the capture edge, while cap_r still holds its reset value,
    // so it decodes the sample that is being captured
    assign mode_ok_live = (sample_s2_r.mode2_lvl == 3'(slm_pkg::SLM_LVL_PD_WEAK))
                       && (sample_s2_r.mode1_lvl == 3'(slm_pkg::SLM_LVL_PD_MED));

    // shares the per-port AND above: a lone negative-line strap leaves port on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            def_r <= '0;
        end else begin
            def_r <= def_nxt;
        end
    end

    assign defaults        = def_r;
    assign straps_captured = cap_r;

    // pin function table: strap default, replaceable by mux writes
    genvar g;
    generate
        for (g = 0; g < NUM_PF; g++) begin : g_pf
            slm_pkg::slm_func_t dflt;
            logic [5:0]         func_r;
            slm_pf_default u_dflt (
                .pin  (5'(g + slm_pkg::PF_FIRST)),
                .func (dflt)
            );
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    func_r <= 6'h00;
                end else if (rst_d_r) begin
                    // reserved mode leaves every pin unconnected
                    func_r <= mode_ok_live ? 6'(dflt) : 6'h00;
                end else if (mux_wr.valid && (mux_wr.pin == 5'(g + slm_pkg::PF_FIRST))) begin
                    func_r <= 6'(mux_wr.func);
                end
            end
            assign pin_function[g] = func_r;
        end
    endgenerate

    // microphone detect, synchronised
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mic_sync_r <= 2'h0;
        end else begin
            mic_sync_r <= {mic_sync_r[0], microphone_detect};
        end
    end
    assign mic_present = mic_sync_r[1];

    // port control pins
    assign port_off = def_r.port_disabled | host_port_disable;

    always_ff @(posedge sys_clk) begin
        // reset to the pulled-up idle level, else release shows a false overcurrent
        if (rst) begin
            oc_s1_r <= '1;
            oc_s2_r <= '1;
        end else begin
            oc_s1_r <= port_power_overcurrent_pin_i;
            oc_s2_r <= oc_s1_r;
        end
    end

    // overcurrent only meaningful while the pin is an input
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_r <= '0;
        end else begin
            oc_r <= ~oc_s2_r & ~port_off;
        end
    end
    assign overcurrent = oc_r;

    // during reset the strap port_disabled is clear, so pins without host_port_disable are inputs with pull-ups,
    // which keeps strap power-off decisions until the straps have settled
    always_comb begin
        port_power_overcurrent_pin_o    = '0;
        port_power_overcurrent_pin_oe_n = ~port_off;
        port_power_overcurrent_pin_pu   = ~port_off;
    end
endmodule
